// *** logic/gdc_gate_ctrl.sv ***
// Our own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
// Behaviour
// - Permit low starts soft turn-off regardless of command inputs.
// - Permit dominates commands; permit pulses shorter than filter time are ignored.
// - Permit shutdown with overcurrent gives soft off without fault indication.
// - Turn-on on noninv rise with inv low, or inv fall with noninv high.
// - Equal command levels give regular turn-off; soft only with simultaneous event.
// - Every turn-on boosts except turn-on from permit rise.
// - Fault cleared by permit low; output updates at next permit rise.
// - Fault indication is pull-down only, set by events, held until cleared.
// - Input undervoltage gives soft turn-off, output undervoltage hard; commands ignored until supplies recover.
// - Output supply loss forces hard sink; after recovery act on commands with boost.
// - Output supply loss drives hard and slow sink together, secondary ready low.
// - Input supply loss gives soft off, watchdog, primary ready low.
// - Primary ready high only with input supplies good and link up.
// - Secondary ready follows output supply and link after short delay.
// - Ready outputs are unlatched status needing no clearing.
// - Link failure for set duration drives slow and hard sink.
// - Every soft turn-off starts 5 us watchdog forcing hard sink.
// - Slope level selects one of 11 turn-on current levels.
// - Turn-off holds the reduced second level for the hold time.
module gdc_gate_ctrl
    import gdc_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RST_I,
    input  wire logic        CE_I,
    // AHB-Lite slave
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic      [31:0] HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    // Command and status pins
    input  wire logic        GATE_PERMIT_I,
    input  wire logic        NONINV_CMD_I,
    input  wire logic        INV_CMD_I,
    input  wire logic        PRIMARY_SUPPLY_OK_I,
    input  wire logic        LOGIC_PAD_SUPPLY_OK_I,
    input  wire logic        SECONDARY_SUPPLY_OK_I,
    input  wire logic        SAT_LOSS_EVENT_I,
    input  wire logic        SHUNT_OC_EVENT_I,
    input  wire logic        LINK_OK_I,
    // Gate drive outputs
    output logic             GATE_ON_O,
    output logic             BOOST_PHASE_O,
    output logic             TWO_STEP_O,
    output logic             SLOW_SINK_O,
    output logic             HARD_SINK_O,
    output logic      [3:0]  SLOPE_LEVEL_O,
    // Status outputs
    output logic             FAULT_N_O,
    output logic             FAULT_N_OE_O,
    output logic             PRIMARY_OK_O,
    output logic             SECONDARY_OK_O
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [SYNC_N-1:0] raw_in;
    logic [SYNC_N-1:0] sync1_reg;
    logic [SYNC_N-1:0] sync2_reg;

    assign raw_in = {LINK_OK_I, SHUNT_OC_EVENT_I, SAT_LOSS_EVENT_I, SECONDARY_SUPPLY_OK_I,
                     LOGIC_PAD_SUPPLY_OK_I, PRIMARY_SUPPLY_OK_I, INV_CMD_I, NONINV_CMD_I,
                     GATE_PERMIT_I};

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else if (CE_I) begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    logic permit_s;
    logic noninv_s;
    logic inv_s;
    logic prim_s;
    logic pad_s;
    logic sec_s;
    logic oc_event;
    logic link_s;

    assign permit_s = sync2_reg[IDX_PERMIT];
    assign noninv_s = sync2_reg[IDX_NONINV];
    assign inv_s    = sync2_reg[IDX_INV];
    assign prim_s   = sync2_reg[IDX_PRIM];
    assign pad_s    = sync2_reg[IDX_PAD];
    assign sec_s    = sync2_reg[IDX_SEC];
    assign oc_event = sync2_reg[IDX_SAT] | sync2_reg[IDX_SHUNT];
    assign link_s   = sync2_reg[IDX_LINK];

    // ----------------------------------------
    // Permit filter and edge history
    // ----------------------------------------
    logic             permit_f_reg;
    logic [CNT_W-1:0] filt_cnt_reg;
    logic             permit_d_reg;
    logic             noninv_d_reg;
    logic             inv_d_reg;
    logic             uv_d_reg;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            permit_f_reg <= 1'b0;
            filt_cnt_reg <= CNT_ZERO;
        end else if (CE_I) begin
            if (permit_s == permit_f_reg) begin
                filt_cnt_reg <= CNT_ZERO;
            end else if (filt_cnt_reg == FILTER_CYC - CNT_ONE) begin
                permit_f_reg <= permit_s;
                filt_cnt_reg <= CNT_ZERO;
            end else begin
                filt_cnt_reg <= filt_cnt_reg + CNT_ONE;
            end
        end
    end

    logic uv_in;
    logic uv_out;
    logic uv_any;

    assign uv_in  = ~prim_s | ~pad_s;
    assign uv_out = ~sec_s;
    assign uv_any = uv_in | uv_out;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            permit_d_reg <= 1'b0;
            noninv_d_reg <= 1'b0;
            inv_d_reg    <= 1'b0;
            uv_d_reg     <= 1'b1;
        end else if (CE_I) begin
            permit_d_reg <= permit_f_reg;
            noninv_d_reg <= noninv_s;
            inv_d_reg    <= inv_s;
            uv_d_reg     <= uv_any;
        end
    end

    logic permit_rise;
    logic cmd_on;
    logic cmd_turn_on;
    logic recover;

    assign permit_rise = permit_f_reg & ~permit_d_reg;
    assign cmd_on      = noninv_s & ~inv_s;
    assign cmd_turn_on = (noninv_s & ~noninv_d_reg & ~inv_s) | (~inv_s & inv_d_reg & noninv_s);
    assign recover     = uv_d_reg & ~uv_any;

    // ----------------------------------------
    // Link watchdog and ready delay
    // ----------------------------------------
    logic [CNT_W-1:0] link_cnt_reg;
    logic [CNT_W-1:0] ready_cnt_reg;
    logic             link_fail;
    logic             sec_ready;

    assign link_fail = (link_cnt_reg == LINK_FAIL_CYC);
    assign sec_ready = (ready_cnt_reg == READY_CYC);

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            link_cnt_reg <= CNT_ZERO;
        end else if (CE_I) begin
            if (link_s) begin
                link_cnt_reg <= CNT_ZERO;
            end else if (!link_fail) begin
                link_cnt_reg <= link_cnt_reg + CNT_ONE;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ready_cnt_reg <= CNT_ZERO;
        end else if (CE_I) begin
            if (!(sec_s && link_s)) begin
                ready_cnt_reg <= CNT_ZERO;
            end else if (!sec_ready) begin
                ready_cnt_reg <= ready_cnt_reg + CNT_ONE;
            end
        end
    end

    logic hard_kill;
    assign hard_kill = uv_out | link_fail;

    // ----------------------------------------
    // Registers written by software
    // ----------------------------------------
    logic [3:0]  slope_reg;
    logic [15:0] hold_reg;

    // ----------------------------------------
    // Drive state machine
    // ----------------------------------------
    gdc_state_type    state_reg;
    gdc_state_type    state_next;
    logic [CNT_W-1:0] phase_cnt_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (!hard_kill && !uv_in && permit_f_reg) begin
                    if (permit_rise && cmd_on) begin
                        state_next = ST_ON;
                    end else if (cmd_turn_on || (recover && cmd_on)) begin
                        state_next = ST_BOOST;
                    end
                end
            end
            ST_BOOST, ST_ON: begin
                if (hard_kill || uv_in || !permit_f_reg) begin
                    state_next = ST_SOFT;
                end else if (state_reg == ST_ON && oc_event) begin
                    state_next = ST_SOFT;
                end else if (!cmd_on) begin
                    state_next = (hold_reg == CNT_ZERO) ? ST_OFF : ST_TWO_STEP;
                end else if (state_reg == ST_BOOST && phase_cnt_reg == BOOST_CYC - CNT_ONE) begin
                    state_next = ST_ON;
                end
            end
            ST_TWO_STEP: begin
                if (hard_kill || uv_in || !permit_f_reg || oc_event) begin
                    state_next = ST_SOFT;
                end else if (phase_cnt_reg == hold_reg - CNT_ONE) begin
                    state_next = ST_OFF;
                end
            end
            ST_SOFT: begin
                // Output supply loss ends soft phase
                if (phase_cnt_reg == WATCHDOG_CYC || uv_out) begin
                    state_next = ST_OFF;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state_reg     <= ST_OFF;
            phase_cnt_reg <= CNT_ZERO;
        end else if (CE_I) begin
            state_reg     <= state_next;
            phase_cnt_reg <= (state_next != state_reg) ? CNT_ZERO : phase_cnt_reg + CNT_ONE;
        end
    end

    // ----------------------------------------
    // Gate drive outputs
    // ----------------------------------------
    logic hard_next;
    logic slow_next;

    // Watchdog and hard kill to hard sink
    assign hard_next = (state_next == ST_OFF) || (state_next == ST_TWO_STEP) || hard_kill
                    || (state_reg == ST_SOFT && phase_cnt_reg >= WATCHDOG_CYC - CNT_ONE);
    // Slow sink together with hard on output supply loss
    assign slow_next = (state_next == ST_SOFT) || hard_kill;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            GATE_ON_O     <= 1'b0;
            BOOST_PHASE_O <= 1'b0;
            TWO_STEP_O    <= 1'b0;
            SLOW_SINK_O   <= 1'b0;
            HARD_SINK_O   <= 1'b1;
            SLOPE_LEVEL_O <= SLOPE_RESET;
        end else if (CE_I) begin
            GATE_ON_O     <= (state_next == ST_BOOST) || (state_next == ST_ON);
            BOOST_PHASE_O <= (state_next == ST_BOOST);
            TWO_STEP_O    <= (state_next == ST_TWO_STEP);
            SLOW_SINK_O   <= slow_next;
            HARD_SINK_O   <= hard_next;
            SLOPE_LEVEL_O <= slope_reg;
        end
    end

    // ----------------------------------------
    // Fault latch
    // ----------------------------------------
    logic fault_reg;
    logic clear_arm_reg;
    logic fault_set;

    // No fault while permit is low
    assign fault_set = (state_reg == ST_ON) && oc_event && permit_f_reg;

    // Clear takes effect at permit rise
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            fault_reg     <= 1'b0;
            clear_arm_reg <= 1'b0;
        end else if (CE_I) begin
            if (!permit_f_reg) begin
                clear_arm_reg <= 1'b1;
            end else if (permit_rise) begin
                clear_arm_reg <= 1'b0;
            end
            if (fault_set) begin
                fault_reg <= 1'b1;
            end else if (permit_rise && clear_arm_reg) begin
                fault_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            FAULT_N_O    <= 1'b0;
            FAULT_N_OE_O <= 1'b0;
        end else if (CE_I) begin
            FAULT_N_O    <= 1'b0;
            FAULT_N_OE_O <= fault_set | (fault_reg & ~(permit_rise & clear_arm_reg));
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            PRIMARY_OK_O   <= 1'b0;
            SECONDARY_OK_O <= 1'b0;
        end else if (CE_I) begin
            PRIMARY_OK_O   <= prim_s & pad_s & link_s;
            SECONDARY_OK_O <= sec_s & link_s & sec_ready;
        end
    end

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            ADDR_SLOPE: w[3:0]  = slope_reg;
            ADDR_HOLD:  w[15:0] = hold_reg;
            ADDR_STATUS: begin
                w[STAT_STATE_LSB +: 3] = state_reg;
                w[STAT_FAULT]          = fault_reg;
                w[STAT_PRIM_OK]        = PRIMARY_OK_O;
                w[STAT_SEC_OK]         = SECONDARY_OK_O;
                w[STAT_LINK_FAIL]      = link_fail;
                w[STAT_UV_IN]          = uv_in;
                w[STAT_UV_OUT]         = uv_out;
            end
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    logic              taken;
    logic              wr_pend_reg;
    logic [ADDR_W-1:0] wr_addr_reg;

    assign taken = HSEL_I && HTRANS_I[1] && HREADY_I;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
            HRDATA_O    <= 32'h0000_0000;
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
        end else if (CE_I) begin
            HREADYOUT_O <= 1'b1;
            HRESP_O     <= 1'b0;
            if (HREADY_I) begin
                wr_pend_reg <= taken && HWRITE_I;
                wr_addr_reg <= HADDR_I[ADDR_W-1:0];
            end
            if (taken && !HWRITE_I) begin
                HRDATA_O <= read_word(HADDR_I[ADDR_W-1:0]);
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            slope_reg <= SLOPE_RESET;
            hold_reg  <= HOLD_RESET;
        end else if (CE_I && wr_pend_reg) begin
            if (wr_addr_reg == ADDR_SLOPE) begin
                if (HWDATA_I[3:0] < SLOPE_MIN) begin
                    slope_reg <= SLOPE_MIN;
                end else if (HWDATA_I[3:0] > SLOPE_MAX) begin
                    slope_reg <= SLOPE_MAX;
                end else begin
                    slope_reg <= HWDATA_I[3:0];
                end
            end
            if (wr_addr_reg == ADDR_HOLD) begin
                hold_reg <= HWDATA_I[15:0];
            end
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I || !CE_I);

    a_permit_soft: assert property (
        state_reg == ST_ON && !permit_f_reg |=> state_reg == ST_SOFT && SLOW_SINK_O)
        else $error("permit low did not start soft off");
    a_filter_len: assert property (
        $changed(permit_f_reg) |-> $past(filt_cnt_reg) == FILTER_CYC - CNT_ONE)
        else $error("permit changed before filter time");
    a_fault_masked: assert property (
        !permit_f_reg && !fault_reg |=> !fault_reg)
        else $error("fault set while permit low");
    a_turn_on: assert property (
        state_reg == ST_OFF && cmd_turn_on && permit_f_reg && !permit_rise
        && !hard_kill && !uv_in |=> state_reg == ST_BOOST && BOOST_PHASE_O && GATE_ON_O)
        else $error("turn-on edge not followed");
    a_regular_off: assert property (
        state_reg == ST_ON && permit_f_reg && !cmd_on && !oc_event && !hard_kill
        && !uv_in |=> !SLOW_SINK_O && !GATE_ON_O)
        else $error("regular turn-off misbehaved");
    a_permit_noboost: assert property (
        state_reg == ST_OFF && permit_rise && cmd_on && !hard_kill && !uv_in
        |=> GATE_ON_O && !BOOST_PHASE_O)
        else $error("permit turn-on used boost");
    a_boost_len: assert property (
        state_reg == ST_BOOST |-> phase_cnt_reg < BOOST_CYC)
        else $error("boost phase too long");
    a_fault_clear: assert property (
        $fell(fault_reg) |-> $past(permit_rise) && $past(clear_arm_reg))
        else $error("fault cleared without permit rise");
    a_fault_set: assert property (
        fault_set |=> FAULT_N_OE_O && !FAULT_N_O ##1 fault_reg)
        else $error("fault not indicated");
    a_uv_soft: assert property (
        state_reg == ST_ON && uv_in && !hard_kill |=> state_reg == ST_SOFT && SLOW_SINK_O)
        else $error("undervoltage did not soft off");
    a_sec_loss: assert property (
        uv_out |=> HARD_SINK_O && SLOW_SINK_O && !SECONDARY_OK_O)
        else $error("output supply loss not handled");
    a_primary_ok: assert property (
        PRIMARY_OK_O == $past(prim_s && pad_s && link_s))
        else $error("primary ready mismatch");
    a_sec_ok: assert property (
        SECONDARY_OK_O |-> $past(sec_s && link_s && sec_ready))
        else $error("secondary ready too early");
    a_link_fail: assert property (
        link_fail |=> HARD_SINK_O && SLOW_SINK_O)
        else $error("link failure not handled");
    a_watchdog_hard: assert property (
        state_reg == ST_SOFT && phase_cnt_reg == WATCHDOG_CYC - CNT_ONE |=> HARD_SINK_O)
        else $error("watchdog did not force hard sink");
    a_slope_range: assert property (
        SLOPE_LEVEL_O >= SLOPE_MIN && SLOPE_LEVEL_O <= SLOPE_MAX)
        else $error("slope level out of range");
    a_two_step: assert property (
        state_reg == ST_TWO_STEP && phase_cnt_reg < hold_reg - CNT_ONE && !hard_kill
        && !uv_in && permit_f_reg && !oc_event |=> state_reg == ST_TWO_STEP && TWO_STEP_O)
        else $error("two-step hold ended early");

    c_turn_on:  cover property (state_reg == ST_BOOST ##1 state_reg == ST_ON);
    c_soft_wd:  cover property (state_reg == ST_SOFT && phase_cnt_reg == WATCHDOG_CYC);
    c_fault:    cover property ($rose(fault_reg));
    c_two_step: cover property (state_reg == ST_TWO_STEP ##1 state_reg == ST_OFF);

endmodule

// *** logic/gdc_pkg.sv ***
package gdc_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS  = 8;
    localparam int WATCHDOG_NS    = 5000;
    localparam int BOOST_NS       = 135;
    localparam int FILTER_NS      = 240;
    localparam int LINK_FAIL_NS   = 2000;
    localparam int READY_DELAY_NS = 1000;

    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] WATCHDOG_CYC = CNT_W'(WATCHDOG_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] BOOST_CYC    =
        CNT_W'((BOOST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] FILTER_CYC   =
        CNT_W'((FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] LINK_FAIL_CYC =
        CNT_W'((LINK_FAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] READY_CYC    =
        CNT_W'((READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CNT_ONE      = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_ZERO     = 16'h0000;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_SLOPE  = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_HOLD   = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;

    localparam logic [3:0]  SLOPE_MIN   = 4'h1;
    localparam logic [3:0]  SLOPE_MAX   = 4'hb;
    localparam logic [3:0]  SLOPE_RESET = 4'ha;
    localparam logic [15:0] HOLD_RESET  = 16'h0010;

    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_FAULT     = 4;
    localparam int STAT_PRIM_OK   = 5;
    localparam int STAT_SEC_OK    = 6;
    localparam int STAT_LINK_FAIL = 7;
    localparam int STAT_UV_IN     = 8;
    localparam int STAT_UV_OUT    = 9;

    // ----------------------------------------
    // Synchronised input positions
    // ----------------------------------------
    localparam int SYNC_N     = 9;
    localparam int IDX_PERMIT = 0;
    localparam int IDX_NONINV = 1;
    localparam int IDX_INV    = 2;
    localparam int IDX_PRIM   = 3;
    localparam int IDX_PAD    = 4;
    localparam int IDX_SEC    = 5;
    localparam int IDX_SAT    = 6;
    localparam int IDX_SHUNT  = 7;
    localparam int IDX_LINK   = 8;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_BOOST,
        ST_ON,
        ST_TWO_STEP,
        ST_SOFT
    } gdc_state_type;

endpackage

// *** testbench/gdc_mcu_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Controller command model
// ----------------------------------------
module gdc_mcu_model (
    // Clock
    input  wire logic clk_i,
    // Request
    input  wire logic run_i,
    input  wire logic inv_mode_i,
    // Command pins
    output logic      noninv_o,
    output logic      inv_o
);
    always_ff @(posedge clk_i) begin
        noninv_o <= inv_mode_i ? 1'b1 : run_i;
        inv_o    <= inv_mode_i ? ~run_i : 1'b0;
    end
endmodule

// *** testbench/gate_drive_control_logic_tb_top.sv ***
`timescale 1ns/1ps
module gate_drive_control_logic_tb_top
    import gdc_pkg::*;
;
    `define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
    logic clk = 0, rst = 1, sel = 0, wr = 0, pmt = 1, run = 0, im = 0;
    logic pri = 1, pad = 1, sec = 1, sat = 0, sho = 0, lnk = 1, nv, iv, rdy, rsp;
    logic on, bst, two, slw, hrd, fn, foe, pok, sok, seen;
    logic [1:0] tr = 0;
    logic [31:0] ad = 0, wd = 0, rd, r, v;
    logic [3:0] lvl;
    int n_fail = 0, comparisons = 0, seed = 32'hc49a;
    always #4 clk = ~clk;
    gdc_mcu_model mcu (.clk_i(clk), .run_i(run), .inv_mode_i(im), .noninv_o(nv), .inv_o(iv));
    gdc_gate_ctrl dut (.CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .HSEL_I(sel), .HADDR_I(ad),
        .HTRANS_I(tr), .HWRITE_I(wr), .HSIZE_I(3'b010), .HWDATA_I(wd), .HREADY_I(rdy),
        .HRDATA_O(rd), .HREADYOUT_O(rdy), .HRESP_O(rsp), .GATE_PERMIT_I(pmt),
        .NONINV_CMD_I(nv), .INV_CMD_I(iv), .PRIMARY_SUPPLY_OK_I(pri),
        .LOGIC_PAD_SUPPLY_OK_I(pad), .SECONDARY_SUPPLY_OK_I(sec), .SAT_LOSS_EVENT_I(sat),
        .SHUNT_OC_EVENT_I(sho), .LINK_OK_I(lnk), .GATE_ON_O(on), .BOOST_PHASE_O(bst),
        .TWO_STEP_O(two), .SLOW_SINK_O(slw), .HARD_SINK_O(hrd), .SLOPE_LEVEL_O(lvl),
        .FAULT_N_O(fn), .FAULT_N_OE_O(foe), .PRIMARY_OK_O(pok), .SECONDARY_OK_O(sok));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] q);
        sel <= 1; tr <= 2'b10; wr <= w; ad <= a;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        tr <= 2'b00; wd <= d;
        @(posedge clk);
        while (rdy !== 1'b1) @(posedge clk);
        q = rd;
        `CHK(rsp, 1'b0)
    endtask
    function automatic logic [3:0] clip(input logic [31:0] v);
        return (v[3:0] < 1) ? 4'h1 : (v[3:0] > 11) ? 4'hb : v[3:0];
    endfunction
    task automatic conclude();
        $display("failures %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        cyc(20000);
        n_fail++;
        conclude();
    end
    initial begin
        cyc(12);
        rst <= 0;
        bus(0, 32'h0, 0, r); `CHK(r[3:0], SLOPE_RESET) // reset level
        bus(0, 32'h4, 0, r); `CHK(r[15:0], HOLD_RESET)
        bus(0, 32'hc, 0, r); `CHK(r, 32'h0)
        for (int i = 0; i < 32; i++) begin
            v = (i < 2) ? i * 15 : $random(seed);
            bus(1, 32'h0, v, r); bus(0, 32'h0, 0, r);
            `CHK(r[3:0], clip(v)) `CHK(lvl, clip(v)) // level range
        end
        bus(1, 32'h4, 32'h4, r);
        bus(0, 32'h8, 0, r); `CHK(r, 32'h60) // status readback
        sel <= 0; run <= 1; cyc(6);
        `CHK(bst, 1'b1) `CHK(on, 1'b1) // turn on with boost
        cyc(25); `CHK(bst, 1'b0) sat <= 1; cyc(6);
        `CHK(foe, 1'b1) `CHK({slw, hrd}, 2'b10) // fault set
        cyc(623); `CHK({slw, hrd}, 2'b11) // watchdog
        cyc(7); sat <= 0; pmt <= 0; cyc(40); `CHK(foe, 1'b1) // held while low
        pmt <= 1; seen = 0;
        repeat (40) begin cyc(1); seen |= bst; end
        `CHK(foe, 1'b0) // fault cleared
        `CHK({on, seen}, 2'b10) // permit turn on
        run <= 0; cyc(5); `CHK({two, hrd}, 2'b11) // two step hold
        cyc(12); `CHK({on, two, slw}, 3'b000) // regular off
        im <= 1; cyc(5); run <= 1; cyc(6); `CHK(bst, 1'b1) // inverting turn on
        pmt <= 0; cyc(40); `CHK({on, slw}, 2'b01) // permit low
        pmt <= 1; cyc(640); `CHK({pok, sok}, 2'b11) // ready
        `CHK({on, hrd}, 2'b01) // off after watchdog
        run <= 0; cyc(5); run <= 1; cyc(30); `CHK({on, bst}, 2'b10) // inverting toggle
        pri <= 0; cyc(5); `CHK({pok, sok, slw, on}, 4'b0110) // input supply loss
        pri <= 1; cyc(5); `CHK(pok, 1'b1) // unlatched
        sec <= 0; cyc(5); `CHK({hrd, slw, sok, pok}, 4'b1101) // output loss
        sec <= 1; cyc(6); `CHK({on, bst}, 2'b11) // recovery turn on
        lnk <= 0; cyc(5); `CHK(pok, 1'b0) // link down
        cyc(260); `CHK({slw, hrd}, 2'b11) // link failure
        conclude();
    end
endmodule
